// ### rtl/asb_cfg.svh
// Purpose: offsets, field positions and reset values of the bank-3 register group
// Assumes: 9-bit data-memory addresses, 8-bit data
// Notes: definitions only
`ifndef ASB_CFG_SVH
`define ASB_CFG_SVH
`define ASB_BANK3_BASE 9'h180
`define ASB_BANK3_LAST 9'h19F
`define ASB_OFS_INDIRECT_PORT 9'h180
`define ASB_OFS_TIMER_OPTION 9'h181
`define ASB_OFS_PC_LOW 9'h182
`define ASB_OFS_STATUS 9'h183
`define ASB_OFS_POINTER 9'h184
`define ASB_OFS_PORT_B_DIR 9'h186
`define ASB_OFS_PORT_F_DIR 9'h187
`define ASB_OFS_PORT_G_DIR 9'h188
`define ASB_OFS_PC_LATCH 9'h18A
`define ASB_OFS_INT_CTRL 9'h18B
`define ASB_BIT_CARRY 0
`define ASB_BIT_NIBBLE_CARRY 1
`define ASB_BIT_ZERO 2
`define ASB_BIT_POWERDOWN 3
`define ASB_BIT_TIMEOUT 4
`define ASB_BIT_DIRECT_LO 5
`define ASB_BIT_DIRECT_HI 6
`define ASB_BIT_INDIRECT 7
`define ASB_RST_OPTION 8'hFF
`define ASB_RST_DIR 8'hFF
`define ASB_RST_ZERO8 8'h00
`define ASB_RST_PC_LATCH 5'h00
`define ASB_RST_STATUS_POR 8'h18
`define ASB_PC_LATCH_W 5
`define ASB_BANK3_CODE 2'h3
`endif

// ### rtl/asb_pkg.sv
// Purpose: shared types of the bank-3 register group
// Assumes: 9-bit addresses and 8-bit data written as literals, matching the config header
// Notes: none
package asb_pkg;
    typedef enum logic [1:0] {
        ASB_RC_NONE,
        ASB_RC_POWERUP,
        ASB_RC_WDT_TIMEOUT,
        ASB_RC_OTHER
    } asb_reset_cause_t;

    typedef struct packed {
        logic [8:0] addr;
        logic wr_en;
        logic rd_en;
        logic [7:0] wr_data;
    } asb_mem_req_t;

    typedef struct packed {
        logic upd_flags;
        logic upd_zero;
        logic is_subtract;
        logic [7:0] op_a;
        logic [7:0] op_b;
        logic [7:0] result;
    } asb_alu_ev_t;

    typedef struct packed {
        logic indirect_bank_sel;
        logic direct_bank_sel_hi;
        logic direct_bank_sel_lo;
        logic watchdog_timeout_flag;
        logic powerdown_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic carry_flag;
    } asb_status_t;
endpackage

// ### rtl/asb_flag_calc.sv
// Purpose: derive zero, nibble carry and carry from an add or subtract
// Assumes: subtract is op_a minus op_b done as op_a plus two's complement of op_b
// Notes: combinational helper
`timescale 1ns/1ps
module asb_flag_calc (
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic is_subtract,
    input wire logic [7:0] result,
    output logic zero_flag,
    output logic nibble_carry_flag,
    output logic carry_flag
);
    wire [7:0] b_eff = is_subtract ? ~op_b : op_b;
    wire [4:0] low_sum = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_subtract};
    wire [8:0] full_sum = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, is_subtract};
    // carry out of subtraction reads as not-borrow
    assign nibble_carry_flag = low_sum[4];
    assign carry_flag = full_sum[8];
    assign zero_flag = (result == 8'h00);
endmodule

// ### rtl/asb_status_bank.sv
// Purpose: bank-3 special registers around the processor status register
// Assumes: core presents one data-memory access per enabled clock
// Notes: read data registered, valid the cycle after rd_en
//
// Behaviour
// - The status register can be the destination of any instruction like other registers.
// - Flag-updating instructions writing status keep their own zero, nibble and carry flags.
// - The time-out and power-down flags ignore all instruction writes.
// - Clear-file on status clears the bank bits, sets zero, keeps the rest.
// - In subtraction carry and nibble carry mean no borrow when one.
// - Unimplemented bank-3 addresses read zero and ignore writes.
// - Status holds ALU flags, reset flags and bank selects in one byte.
// - Direct bank bits pick one of four banks, 11 is bank 3; indirect bit picks half.
// - Time-out flag set by power-up, watchdog clear or sleep, cleared by watchdog time-out.
// - Power-down flag set by power-up or watchdog clear, cleared by sleep.
// - Nibble carry is carry out of bit 3, carry is carry out of bit 7.
`timescale 1ns/1ps
`include "asb_cfg.svh"
module asb_status_bank #(
    parameter int PC_LATCH_W = `ASB_PC_LATCH_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire asb_pkg::asb_reset_cause_t reset_cause,
    input wire asb_pkg::asb_mem_req_t mem_req,
    input wire logic clear_file_instr,
    input wire asb_pkg::asb_alu_ev_t alu_ev,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    input wire logic [7:0] indirect_data,
    output logic [7:0] rd_data,
    output asb_pkg::asb_status_t status_out,
    output logic bank3_direct_sel,
    output logic [8:0] indirect_addr,
    output logic [7:0] timer_option_control,
    output logic [7:0] program_counter_low,
    output logic [PC_LATCH_W-1:0] pc_upper_write_latch,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_f_direction,
    output logic [7:0] port_g_direction,
    output logic [7:0] interrupt_control,
    output logic indirect_wr_en,
    output logic [7:0] indirect_wr_data
);
    asb_pkg::asb_status_t status_reg;
    asb_pkg::asb_status_t status_next;
    asb_pkg::asb_status_t status_load;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic [7:0] pointer_reg;
    logic bank3_reg;
    logic ind_wr_reg;
    logic [7:0] ind_wd_reg;

    wire logic calc_zero;
    wire logic calc_nc;
    wire logic calc_carry;

    asb_flag_calc u_flag_calc (
        .op_a(alu_ev.op_a),
        .op_b(alu_ev.op_b),
        .is_subtract(alu_ev.is_subtract),
        .result(alu_ev.result),
        .zero_flag(calc_zero),
        .nibble_carry_flag(calc_nc),
        .carry_flag(calc_carry)
    );

    // address decode
    wire logic in_bank3 = (mem_req.addr >= `ASB_BANK3_BASE) && (mem_req.addr <= `ASB_BANK3_LAST);
    wire logic wr = mem_req.wr_en && in_bank3;
    wire logic sel_status = (mem_req.addr == `ASB_OFS_STATUS);
    wire logic sel_option = (mem_req.addr == `ASB_OFS_TIMER_OPTION);
    wire logic sel_pcl = (mem_req.addr == `ASB_OFS_PC_LOW);
    wire logic sel_ptr = (mem_req.addr == `ASB_OFS_POINTER);
    wire logic sel_dirb = (mem_req.addr == `ASB_OFS_PORT_B_DIR);
    wire logic sel_dirf = (mem_req.addr == `ASB_OFS_PORT_F_DIR);
    wire logic sel_dirg = (mem_req.addr == `ASB_OFS_PORT_G_DIR);
    wire logic sel_latch = (mem_req.addr == `ASB_OFS_PC_LATCH);
    wire logic sel_intc = (mem_req.addr == `ASB_OFS_INT_CTRL);
    wire logic sel_ind = (mem_req.addr == `ASB_OFS_INDIRECT_PORT);
    wire logic wr_status = wr && sel_status;
    wire logic clr_status = wr_status && clear_file_instr;
    wire logic alu_any = alu_ev.upd_flags || alu_ev.upd_zero;

    // status next value
    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next.indirect_bank_sel = mem_req.wr_data[`ASB_BIT_INDIRECT];
            status_next.direct_bank_sel_hi = mem_req.wr_data[`ASB_BIT_DIRECT_HI];
            status_next.direct_bank_sel_lo = mem_req.wr_data[`ASB_BIT_DIRECT_LO];
        end
        // a flag-updating instruction drops all three data flags
        if (wr_status && !alu_any) begin
            status_next.zero_flag = mem_req.wr_data[`ASB_BIT_ZERO];
            status_next.nibble_carry_flag = mem_req.wr_data[`ASB_BIT_NIBBLE_CARRY];
            status_next.carry_flag = mem_req.wr_data[`ASB_BIT_CARRY];
        end
        if (clr_status) begin
            status_next.indirect_bank_sel = 1'b0;
            status_next.direct_bank_sel_hi = 1'b0;
            status_next.direct_bank_sel_lo = 1'b0;
            status_next.zero_flag = 1'b1;
            status_next.nibble_carry_flag = status_reg.nibble_carry_flag;
            status_next.carry_flag = status_reg.carry_flag;
        end
        // flag results override the data write
        if (alu_ev.upd_zero) begin
            status_next.zero_flag = calc_zero;
        end
        if (alu_ev.upd_flags) begin
            status_next.nibble_carry_flag = calc_nc;
            status_next.carry_flag = calc_carry;
        end
        // reset-cause flags never come from writes
        if (watchdog_clear_instr) begin
            status_next.watchdog_timeout_flag = 1'b1;
            status_next.powerdown_flag = 1'b1;
        end else if (sleep_instr) begin
            status_next.watchdog_timeout_flag = 1'b1;
            status_next.powerdown_flag = 1'b0;
        end
        if (watchdog_timeout) begin
            status_next.watchdog_timeout_flag = 1'b0;
        end
    end

    // read mux, unmapped bank-3 addresses give zero
    always_comb begin
        rd_data_next = 8'h00;
        if (mem_req.rd_en && in_bank3) begin
            if (sel_status) rd_data_next = status_reg;
            else if (sel_option) rd_data_next = timer_option_control;
            else if (sel_pcl) rd_data_next = program_counter_low;
            else if (sel_ptr) rd_data_next = pointer_reg;
            else if (sel_dirb) rd_data_next = port_b_direction;
            else if (sel_dirf) rd_data_next = port_f_direction;
            else if (sel_dirg) rd_data_next = port_g_direction;
            else if (sel_latch) rd_data_next = {{(8-PC_LATCH_W){1'b0}}, pc_upper_write_latch};
            else if (sel_intc) rd_data_next = interrupt_control;
            else if (sel_ind) rd_data_next = indirect_data;
            else rd_data_next = 8'h00;
        end
    end

    // reset causes override the instruction path
    always_comb begin
        case (reset_cause)
            asb_pkg::ASB_RC_POWERUP: begin
                status_load = `ASB_RST_STATUS_POR;
            end
            asb_pkg::ASB_RC_WDT_TIMEOUT: begin
                status_load = {3'b000, 1'b0, 1'b1, status_reg[2:0]};
            end
            asb_pkg::ASB_RC_OTHER: begin
                status_load = {3'b000, status_reg[4:0]};
            end
            default: begin
                status_load = status_next;
            end
        endcase
    end

    // rst_b always loads the power-up value; cause-dependent values arrive through status_load when clk_en is high
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            status_reg <= `ASB_RST_STATUS_POR;
        end else if (clk_en) begin
            status_reg <= status_load;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            timer_option_control <= `ASB_RST_OPTION;
            program_counter_low <= `ASB_RST_ZERO8;
            pc_upper_write_latch <= PC_LATCH_W'(`ASB_RST_PC_LATCH);
            port_b_direction <= `ASB_RST_DIR;
            port_f_direction <= `ASB_RST_DIR;
            port_g_direction <= `ASB_RST_DIR;
            interrupt_control <= `ASB_RST_ZERO8;
            pointer_reg <= `ASB_RST_ZERO8;
        end else if (clk_en) begin
            if (wr && sel_option) timer_option_control <= mem_req.wr_data;
            if (wr && sel_pcl) program_counter_low <= mem_req.wr_data;
            if (wr && sel_latch) pc_upper_write_latch <= mem_req.wr_data[PC_LATCH_W-1:0];
            if (wr && sel_dirb) port_b_direction <= mem_req.wr_data;
            if (wr && sel_dirf) port_f_direction <= mem_req.wr_data;
            if (wr && sel_dirg) port_g_direction <= mem_req.wr_data;
            if (wr && sel_intc) interrupt_control <= mem_req.wr_data;
            if (wr && sel_ptr) pointer_reg <= mem_req.wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_data_reg <= 8'h00;
            bank3_reg <= 1'b0;
            ind_wr_reg <= 1'b0;
            ind_wd_reg <= 8'h00;
        end else if (clk_en) begin
            rd_data_reg <= rd_data_next;
            // follows the value status takes at this edge, reset causes included
            bank3_reg <= ({status_load.direct_bank_sel_hi, status_load.direct_bank_sel_lo}
                          == `ASB_BANK3_CODE);
            ind_wr_reg <= wr && sel_ind;
            ind_wd_reg <= mem_req.wr_data;
        end
    end

    // outputs straight from the registers
    assign rd_data = rd_data_reg;
    assign status_out = status_reg;
    assign bank3_direct_sel = bank3_reg;
    assign indirect_addr = {status_reg.indirect_bank_sel, pointer_reg};
    assign indirect_wr_en = ind_wr_reg;
    assign indirect_wr_data = ind_wd_reg;
endmodule

// ### verification/asb_status_monitor.sv
// Purpose: port-level checks of the bank-3 status register group
// Assumes: single clock, sync active-low reset
// Notes: bound into every asb_status_bank
`timescale 1ns/1ps
`include "asb_cfg.svh"
module asb_status_monitor (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire asb_pkg::asb_reset_cause_t reset_cause,
    input wire asb_pkg::asb_mem_req_t mem_req,
    input wire logic clear_file_instr,
    input wire asb_pkg::asb_alu_ev_t alu_ev,
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    input wire logic [7:0] rd_data,
    input wire asb_pkg::asb_status_t status_out,
    input wire logic bank3_direct_sel,
    input wire logic [8:0] indirect_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic [8:0] a = mem_req.addr;
    wire logic rc_none = reset_cause == asb_pkg::ASB_RC_NONE;
    wire logic ev_none = !watchdog_clear_instr && !sleep_instr && !watchdog_timeout;
    wire logic quiet = clk_en && rc_none && ev_none;
    wire logic st_wr = quiet && mem_req.wr_en && a == `ASB_OFS_STATUS;
    wire logic no_alu = !alu_ev.upd_flags && !alu_ev.upd_zero;
    wire logic unimpl = a == 9'h185 || a == 9'h189 || (a >= 9'h18C && a <= `ASB_BANK3_LAST);
    wire logic [7:0] ob = alu_ev.is_subtract ? ~alu_ev.op_b : alu_ev.op_b;
    wire logic [8:0] sum = {1'b0, alu_ev.op_a} + {1'b0, ob} + {8'h00, alu_ev.is_subtract};
    wire logic [4:0] nib = {1'b0, alu_ev.op_a[3:0]} + {1'b0, ob[3:0]} + {4'h0, alu_ev.is_subtract};
    sequence s_bank_cleared;
        status_out[7:5] == 3'h0 && status_out.zero_flag;
    endsequence
    property p_status_wr;
        st_wr && no_alu && !clear_file_instr |=>
            {status_out[7:5], status_out[2:0]} == $past({mem_req.wr_data[7:5], mem_req.wr_data[2:0]});
    endproperty
    a_status_wr: assert property (p_status_wr) else $error("status write lost");
    property p_zero_prio;
        st_wr && alu_ev.upd_zero && !clear_file_instr |=> status_out.zero_flag == $past(alu_ev.result == 8'h00);
    endproperty
    a_zero_prio: assert property (p_zero_prio) else $error("zero not from result");
    property p_flag_guard;
        st_wr && alu_ev.upd_zero && !alu_ev.upd_flags |=> $stable(status_out[1:0]);
    endproperty
    a_flag_guard: assert property (p_flag_guard) else $error("data reached carry flags");
    property p_flag_calc;
        quiet && alu_ev.upd_flags && !clear_file_instr |=> status_out[1:0] == $past({nib[4], sum[8]});
    endproperty
    a_flag_calc: assert property (p_flag_calc) else $error("carry flags wrong");
    property p_ro_flags;
        quiet && mem_req.wr_en |=> $stable(status_out[4:3]);
    endproperty
    a_ro_flags: assert property (p_ro_flags) else $error("reset flags written");
    property p_clear_file;
        st_wr && clear_file_instr && no_alu |=> s_bank_cleared ##0 $stable({status_out[4:3], status_out[1:0]});
    endproperty
    a_clear_file: assert property (p_clear_file) else $error("clear-file result wrong");
    property p_unimpl_rd;
        clk_en && mem_req.rd_en && unimpl |=> rd_data == 8'h00;
    endproperty
    a_unimpl_rd: assert property (p_unimpl_rd) else $error("hole read not zero");
    property p_unimpl_wr;
        quiet && mem_req.wr_en && unimpl && no_alu |=> $stable(status_out) && $stable(indirect_addr);
    endproperty
    a_unimpl_wr: assert property (p_unimpl_wr) else $error("hole write had effect");
    property p_status_rd;
        clk_en && mem_req.rd_en && a == `ASB_OFS_STATUS |=> rd_data == $past(status_out);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status read wrong");
    property p_bank_sel;
        bank3_direct_sel == (status_out[6:5] == `ASB_BANK3_CODE)
            && indirect_addr[8] == status_out[7];
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank select wrong");
    property p_timeout;
        clk_en && rc_none && watchdog_timeout |=> !status_out.watchdog_timeout_flag;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag kept");
    property p_sleep;
        clk_en && rc_none && sleep_instr && !watchdog_timeout |=> status_out[4:3] == 2'h2;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_wdt_clear;
        clk_en && rc_none && watchdog_clear_instr && !sleep_instr && !watchdog_timeout |=>
            status_out[4:3] == 2'h3;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("clear flags wrong");
endmodule
bind asb_status_bank asb_status_monitor asb_status_monitor_inst (.ref_clk, .rst_b, .clk_en,
    .reset_cause, .mem_req, .clear_file_instr, .alu_ev, .watchdog_clear_instr, .sleep_instr,
    .watchdog_timeout, .rd_data, .status_out, .bank3_direct_sel, .indirect_addr);

// ### verification/asb_status_bank_tb.sv
// Purpose: directed bench for the bank-3 status register group
// Assumes: one access per two cycles, results checked 1 ns after the sampling edge
// Notes: indirect_data tied
`timescale 1ns/1ps
module asb_status_bank_tb;
    logic ref_clk = 0, rst_b = 0, clk_en = 1, clear_file_instr = 0;
    logic watchdog_clear_instr = 0, sleep_instr = 0, watchdog_timeout = 0;
    asb_pkg::asb_reset_cause_t reset_cause = asb_pkg::ASB_RC_NONE;
    asb_pkg::asb_mem_req_t mem_req = '0;
    asb_pkg::asb_alu_ev_t alu_ev = '0;
    asb_pkg::asb_status_t status_out;
    logic [7:0] indirect_data = 8'hA5, rd_data, timer_option_control, program_counter_low;
    logic [7:0] port_b_direction, port_f_direction, port_g_direction, interrupt_control;
    logic [7:0] indirect_wr_data;
    logic [4:0] pc_upper_write_latch;
    logic [8:0] indirect_addr;
    logic bank3_direct_sel, indirect_wr_en;
    int errors = 0, checked = 0;
    asb_status_bank asb_status_bank_inst (.ref_clk, .rst_b, .clk_en, .reset_cause, .mem_req,
        .clear_file_instr, .alu_ev, .watchdog_clear_instr, .sleep_instr, .watchdog_timeout,
        .indirect_data, .rd_data, .status_out, .bank3_direct_sel, .indirect_addr,
        .timer_option_control, .program_counter_low, .pc_upper_write_latch, .port_b_direction,
        .port_f_direction, .port_g_direction, .interrupt_control, .indirect_wr_en,
        .indirect_wr_data);
    initial forever #10 ref_clk = ~ref_clk;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // p: 4 clk_en low, 3 timeout, 2 sleep, 1 watchdog clear, 0 clear-file
    task cyc(input logic [8:0] a, input logic w, input logic r, input logic [7:0] d,
            input logic [4:0] p = 5'h00, input asb_pkg::asb_alu_ev_t ev = '0,
            input asb_pkg::asb_reset_cause_t rc = asb_pkg::ASB_RC_NONE);
        @(posedge ref_clk);
        mem_req <= '{a, w, r, d};
        {watchdog_timeout, sleep_instr, watchdog_clear_instr, clear_file_instr} <= p[3:0];
        clk_en <= !p[4];
        alu_ev <= ev;
        reset_cause <= rc;
        @(posedge ref_clk);
        mem_req <= '0;
        {watchdog_timeout, sleep_instr, watchdog_clear_instr, clear_file_instr} <= 4'h0;
        clk_en <= 1'b1;
        alu_ev <= '0;
        reset_cause <= asb_pkg::ASB_RC_NONE;
        #1;
    endtask
    task t_rstval;
        chk(status_out, 8'h18);
        chk(timer_option_control, 8'hFF);
        chk(port_b_direction & port_f_direction & port_g_direction, 8'hFF);
        chk(program_counter_low | interrupt_control | {3'h0, pc_upper_write_latch}, 8'h00);
    endtask
    task t_regs;
        logic [8:0] rw[7] = '{9'h181, 9'h182, 9'h184, 9'h186, 9'h187, 9'h188, 9'h18B};
        foreach (rw[i]) begin
            cyc(rw[i], 1, 0, 8'h5A);
            cyc(rw[i], 0, 1, 8'h00);
            chk(rd_data, 8'h5A);
        end
        chk(indirect_addr[7:0], 8'h5A);
        cyc(9'h18A, 1, 0, 8'hFA);
        cyc(9'h18A, 0, 1, 8'h00);
        chk(rd_data, 8'h1A);
        cyc(9'h180, 0, 1, 8'h00);
        chk(rd_data, 8'hA5);
        @(posedge ref_clk);
        mem_req <= '{9'h180, 1'b1, 1'b0, 8'h3C};
        @(posedge ref_clk);
        mem_req <= '0;
        #1;
        chk({7'h0, indirect_wr_en}, 8'h01);
        chk(indirect_wr_data, 8'h3C);
    endtask
    task t_status_wr;
        cyc(9'h000, 0, 0, 8'h00, 5'h04);
        chk(status_out, 8'h10);
        cyc(9'h183, 1, 0, 8'hFF);
        chk(status_out, 8'hF7);
        chk({6'h0, bank3_direct_sel, indirect_addr[8]}, 8'h03);
        cyc(9'h183, 0, 1, 8'h00);
        chk(rd_data, 8'hF7);
        cyc(9'h183, 1, 0, 8'h40);
        chk(status_out, 8'h50);
        chk({7'h0, bank3_direct_sel}, 8'h00);
        cyc(9'h183, 1, 0, 8'hFF, 5'h10);
        chk(status_out, 8'h50);
    endtask
    task t_reset_flags;
        cyc(9'h000, 0, 0, 8'h00, 5'h02);
        chk(status_out, 8'h58);
        cyc(9'h000, 0, 0, 8'h00, 5'h08);
        chk(status_out, 8'h48);
        cyc(9'h000, 0, 0, 8'h00, 5'h0C);
        chk(status_out, 8'h40);
        cyc(9'h000, 0, 0, 8'h00, 5'h00, '0, asb_pkg::ASB_RC_WDT_TIMEOUT);
        chk(status_out, 8'h08);
        cyc(9'h183, 1, 0, 8'hE5);
        cyc(9'h000, 0, 0, 8'h00, 5'h00, '0, asb_pkg::ASB_RC_OTHER);
        chk(status_out, 8'h0D);
        chk({7'h0, bank3_direct_sel}, 8'h00);
        cyc(9'h000, 0, 0, 8'h00, 5'h00, '0, asb_pkg::ASB_RC_POWERUP);
        chk(status_out, 8'h18);
    endtask
    task t_flags;
        logic [16:0] tv[5] = '{{1'b0, 16'h0F01}, {1'b0, 16'hFF01}, {1'b1, 16'h0503},
            {1'b1, 16'h0305}, {1'b1, 16'h1001}};
        logic [7:0] x, y, r;
        logic [2:0] f;
        foreach (tv[i]) begin
            {x, y} = tv[i][15:0];
            r = tv[i][16] ? x - y : x + y;
            f[0] = tv[i][16] ? x >= y : {1'b0, x} + {1'b0, y} > 9'h0FF;
            f[1] = tv[i][16] ? x[3:0] >= y[3:0] : {1'b0, x[3:0]} + {1'b0, y[3:0]} > 5'h0F;
            f[2] = r == 8'h00;
            cyc(9'h183, 1, 0, {5'h00, ~f}, 5'h00, '{1'b1, 1'b1, tv[i][16], x, y, r});
            chk(status_out, {5'h03, f});
        end
        cyc(9'h183, 1, 0, 8'h06, 5'h00, '{1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00});
        chk(status_out, 8'h1D);
        cyc(9'h183, 1, 0, 8'hE1);
        cyc(9'h183, 1, 0, 8'h00, 5'h01);
        chk(status_out, 8'h1D);
    endtask
    task t_unimpl;
        for (logic [8:0] a = 9'h185; a < 9'h1A2; a++) begin
            if (a > 9'h185 && a < 9'h18C && a != 9'h189) continue;
            cyc(a, 1, 0, 8'hFF);
            cyc(a, 0, 1, 8'h00);
            chk(rd_data, 8'h00);
            chk(status_out, 8'h1D);
        end
        chk(timer_option_control, 8'h5A);
    endtask
    task conclude;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        t_rstval();
        t_regs();
        t_status_wr();
        t_reset_flags();
        t_flags();
        t_unimpl();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        t_rstval();
        conclude();
    end
endmodule
